/* verilog/tsp_pkg.sv */
// package: register map, field positions, mode codes and timing for the two-wire serial port control
package tsp_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_CON1   = 8'h00;
  localparam logic [7:0] OFF_CON2   = 8'h04;
  localparam logic [7:0] OFF_CON3   = 8'h08;
  localparam logic [7:0] OFF_RELOAD = 8'h0C;
  localparam logic [7:0] OFF_BUF    = 8'h10;
  localparam logic [7:0] OFF_IRQST  = 8'h14;
  localparam logic [7:0] OFF_IRQMSK = 8'h18;
  localparam logic [7:0] OFF_STAT   = 8'h1C;
  // control one fields
  localparam int CON1_OVF  = 6;
  localparam int CON1_EN   = 5;
  localparam int CON1_CKR  = 4;
  // control two fields
  localparam int CON2_ACK  = 4;
  localparam int CON2_STOP = 2;
  localparam int CON2_RST  = 1;
  localparam int CON2_STRT = 0;
  // control three fields
  localparam int CON3_ACKT = 7;
  localparam int CON3_PCIE = 6;
  localparam int CON3_START_DETECT_IRQ_ENABLE = 5;
  localparam int CON3_BUFFER_OVERWRITE_ENABLE = 4;
  localparam int CON3_HT   = 3;
  localparam int CON3_SBCD = 2;
  localparam int CON3_ADDRESS_HOLD_ENABLE = 1;
  localparam int CON3_DATA_HOLD_ENABLE = 0;
  // interrupt status bits
  localparam int IRQ_START = 0;
  localparam int IRQ_STOP  = 1;
  localparam int IRQ_COLL  = 2;
  localparam int IRQ_BYTE  = 3;
  localparam int IRQ_SEQ   = 4;
  localparam int IRQ_W     = 5;
  // mode codes
  localparam logic [3:0] MODE_S10_SP = 4'hF;
  localparam logic [3:0] MODE_S7_SP  = 4'hE;
  localparam logic [3:0] MODE_FWMST  = 4'hB;
  localparam logic [3:0] MODE_HWMST  = 4'h8;
  localparam logic [3:0] MODE_S10    = 4'h7;
  localparam logic [3:0] MODE_S7     = 4'h6;
  localparam logic [3:0] MODE_SPI_S  = 4'h4;
  localparam logic [3:0] MODE_SPI_SN = 4'h5;
  // reset values
  localparam logic [7:0] RST_CON1 = 8'h10;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // timing
  localparam int CLK_MHZ     = 50;
  localparam int HOLD_LNG_NS = 300;
  localparam int HOLD_SHT_NS = 100;
  localparam int HOLD_LNG_CY = (HOLD_LNG_NS * CLK_MHZ + 999) / 1000;
  localparam int HOLD_SHT_CY = (HOLD_SHT_NS * CLK_MHZ + 999) / 1000;
  // bus sequence kinds
  typedef enum logic [1:0] {SEQ_START, SEQ_RSTART, SEQ_STOP, SEQ_ACK} tsp_seq_t;
  // apb request carrier
  typedef struct packed {
    logic        sel;
    logic        en;
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } tsp_apb_req_t;
endpackage : tsp_pkg

/* verilog/tsp_brg.sv */
// file: bit-rate divider giving a one-cycle tick every reload+1 clocks
`timescale 1ns/1ps
module tsp_brg #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         run_i,
  input  wire logic [W-1:0] reload_i,
  output logic              tick_o
);
  logic [W-1:0] cnt;
  // half-period tick; two ticks per bus clock period gives osc/(2*(reload+1))
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt    <= '0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      cnt    <= reload_i;
      tick_o <= 1'b0;
    end else if (cnt == '0) begin
      cnt    <= reload_i;
      tick_o <= 1'b1;
    end else begin
      cnt    <= cnt - W'(1);
      tick_o <= 1'b0;
    end
  end
endmodule : tsp_brg

/* verilog/tsp_hold.sv */
// file: data-line hold timer after a bus clock falling edge
`timescale 1ns/1ps
module tsp_hold (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  input  wire logic fall_i,
  input  wire logic long_i,
  output logic      busy_o
);
  logic [4:0] cnt;
  // counts the hold window; data line changes only once busy drops
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= '0;
    end else if (fall_i) begin
      cnt <= long_i ? 5'(tsp_pkg::HOLD_LNG_CY) : 5'(tsp_pkg::HOLD_SHT_CY);
    end else if (cnt != '0) begin
      cnt <= cnt - 5'h01;
    end
  end
  assign busy_o = (cnt != '0);
endmodule : tsp_hold

/* verilog/tsp_ctrl.sv */
// file: top of the two-wire serial port control with apb registers
//
// Function
// - mode field selects slave, master variants
// - master clock is osc/(2*(reload+1))
// - repeated start generated, bit self-clears in hardware master mode only
// - ack flag set fall8, cleared rise9
// - start/stop enables ignored in such modes
// - data hold 300 or 100 ns
// - slave collision irq never raised, even when enabled
// - address hold stretches clock after match
// - ack flag active only with holding
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module tsp_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             scl_oe_o,
  output logic             sda_oe_o,
  output logic             irq_o
);
  tsp_pkg::tsp_apb_req_t req;
  logic [7:0] con1, con2, con3, reload, rxbuf, txbuf, shreg;
  logic [tsp_pkg::IRQ_W-1:0] irq_st, irq_msk, irq_set;
  logic [3:0] mode, bitcnt;
  logic       en, master, slave, spi_slave, sp_mode, busy, wr, rd;
  logic       scl_q, sda_q, scl_rise, scl_fall, start_det, stop_det;
  logic       addr_phase, addr_match, bf, tick, hold_busy;
  logic       seq_act, seq_end, seq_ph, next_scl_oe, next_sda_oe;
  logic       coll;
  tsp_pkg::tsp_seq_t seq;

  assign req = '{sel: psel_i, en: penable_i, wr: pwrite_i, addr: paddr_i, wdata: pwdata_i};
  // a write lands once, at the edge where the master sees pready; a second pass would re-clear w1c bits
  assign wr  = req.sel && req.en && req.wr && pready_o;
  // read side effects go with the data capture, so a byte landing later is not cleared unseen
  assign rd  = req.sel && req.en && !req.wr && !pready_o;

  // mode decode
  assign mode      = con1[3:0];
  assign en        = con1[tsp_pkg::CON1_EN];
  assign master    = en && (mode == tsp_pkg::MODE_HWMST || mode == tsp_pkg::MODE_FWMST);
  assign slave     = en && (mode == tsp_pkg::MODE_S7 || mode == tsp_pkg::MODE_S10 ||
                            mode == tsp_pkg::MODE_S7_SP || mode == tsp_pkg::MODE_S10_SP);
  assign sp_mode   = (mode == tsp_pkg::MODE_S7_SP || mode == tsp_pkg::MODE_S10_SP);
  assign spi_slave = en && (mode == tsp_pkg::MODE_SPI_S || mode == tsp_pkg::MODE_SPI_SN);
  assign busy      = seq_act;

  // bus edge and condition detection; pins are already synchronous
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end
  assign scl_rise  = scl_i && !scl_q;
  assign scl_fall  = !scl_i && scl_q;
  assign start_det = scl_i && scl_q && sda_q && !sda_i;
  assign stop_det  = scl_i && scl_q && !sda_q && sda_i;

  // bit-rate divider, runs only for the hardware master sequence generator
  tsp_brg #(.W(8)) u_brg (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .run_i    (seq_act && mode == tsp_pkg::MODE_HWMST),
    .reload_i (reload),
    .tick_o   (tick)
  );

  // data-line hold window after each falling clock edge
  tsp_hold u_hold (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .fall_i (scl_fall),
    .long_i (con3[tsp_pkg::CON3_HT]),
    .busy_o (hold_busy)
  );

  // byte receive shift and bit count; counter tracks rising edges of each 9-bit frame
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bitcnt     <= 4'h0;
      shreg      <= 8'h00;
      addr_phase <= 1'b1;
    end else if (start_det) begin
      bitcnt     <= 4'h0;
      addr_phase <= 1'b1;
    end else if (scl_rise && (slave || spi_slave)) begin
      shreg  <= {shreg[6:0], sda_i};
      bitcnt <= (bitcnt == 4'h8) ? 4'h0 : bitcnt + 4'h1;
      if (bitcnt == 4'h8) begin
        addr_phase <= 1'b0;
      end
    end
  end
  assign addr_match = (shreg[7:1] == reload[7:1]);

  // sequence engine: start, repeated start, stop, ack each take two ticks
  assign seq_end = seq_act && tick && seq_ph;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      seq_act <= 1'b0;
      seq_ph  <= 1'b0;
      seq     <= tsp_pkg::SEQ_START;
    end else if (!seq_act) begin
      seq_ph <= 1'b0;
      if (master && wr && req.addr == tsp_pkg::OFF_CON2) begin
        seq_act <= |req.wdata[4:0];
        if (req.wdata[tsp_pkg::CON2_STRT]) begin
          seq <= tsp_pkg::SEQ_START;
        end else if (req.wdata[tsp_pkg::CON2_RST]) begin
          seq <= tsp_pkg::SEQ_RSTART;
        end else if (req.wdata[tsp_pkg::CON2_STOP]) begin
          seq <= tsp_pkg::SEQ_STOP;
        end else begin
          seq <= tsp_pkg::SEQ_ACK;
        end
      end
    end else if (tick) begin
      seq_ph <= !seq_ph;
      if (seq_ph) begin
        seq_act <= 1'b0;
      end
    end
  end

  // open-drain drive for master sequences and slave clock stretch
  always_comb begin
    next_sda_oe = 1'b0;
    next_scl_oe = slave && !con1[tsp_pkg::CON1_CKR] && !scl_i;
    if (seq_act) begin
      case (seq)
        tsp_pkg::SEQ_START:  next_sda_oe = 1'b1;
        tsp_pkg::SEQ_RSTART: begin
          next_sda_oe = seq_ph;
          next_scl_oe = 1'b0;
        end
        tsp_pkg::SEQ_STOP:   next_sda_oe = !seq_ph;
        tsp_pkg::SEQ_ACK:    begin
          next_sda_oe = 1'b1;
          next_scl_oe = !seq_ph;
        end
        default:             next_sda_oe = 1'b0;
      endcase
    end else if (hold_busy) begin
      next_sda_oe = sda_oe_o;
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_oe_o <= 1'b0;
      sda_oe_o <= 1'b0;
    end else begin
      scl_oe_o <= next_scl_oe;
      sda_oe_o <= next_sda_oe;
    end
  end

  // collision: line low while we released it, masked by a constant zero so never raised
  assign coll = slave && !sda_oe_o && !hold_busy && scl_rise && !sda_i && 1'b0;

  // control registers; hardware-side updates win over software
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      con1   <= tsp_pkg::RST_CON1;
      con2   <= tsp_pkg::RST_ZERO;
      con3   <= tsp_pkg::RST_ZERO;
      reload <= tsp_pkg::RST_ZERO;
      txbuf  <= tsp_pkg::RST_ZERO;
      rxbuf  <= tsp_pkg::RST_ZERO;
      bf     <= 1'b0;
    end else begin
      if (wr && req.addr == tsp_pkg::OFF_CON1) begin
        con1 <= req.wdata[7:0];
      end
      if (wr && req.addr == tsp_pkg::OFF_CON2 && !busy) begin
        con2 <= req.wdata[7:0];
      end
      if (wr && req.addr == tsp_pkg::OFF_CON3) begin
        con3[6:0] <= req.wdata[6:0];
      end
      if (wr && req.addr == tsp_pkg::OFF_RELOAD) begin
        reload <= req.wdata[7:0];
      end
      if (wr && req.addr == tsp_pkg::OFF_BUF && !busy) begin
        txbuf <= req.wdata[7:0];
      end
      if (rd && req.addr == tsp_pkg::OFF_BUF) begin
        bf <= 1'b0;
      end
      if (seq_end) begin
        con2[4:0] <= 5'h00;
      end
      // acknowledge slot flag
      if (!(con3[tsp_pkg::CON3_ADDRESS_HOLD_ENABLE] || con3[tsp_pkg::CON3_DATA_HOLD_ENABLE])) begin
        con3[tsp_pkg::CON3_ACKT] <= 1'b0;
      end else if (slave && scl_fall && bitcnt == 4'h8) begin
        con3[tsp_pkg::CON3_ACKT] <= 1'b1;
      end else if (scl_rise && bitcnt == 4'h8) begin
        con3[tsp_pkg::CON3_ACKT] <= 1'b0;
      end
      // completed byte in receive buffer and clock stretch
      if ((slave || spi_slave) && scl_fall && bitcnt == 4'h8) begin
        if (bf) begin
          con1[tsp_pkg::CON1_OVF] <= 1'b1;
        end
        // only the spi slave overwrites a full buffer; a two-wire slave keeps the unread byte
        if (!bf || (spi_slave && con3[tsp_pkg::CON3_BUFFER_OVERWRITE_ENABLE])) begin
          rxbuf <= shreg;
          bf    <= 1'b1;
        end
        if (slave && ((addr_phase && addr_match && con3[tsp_pkg::CON3_ADDRESS_HOLD_ENABLE]) ||
                      (!addr_phase && con3[tsp_pkg::CON3_DATA_HOLD_ENABLE]))) begin
          con1[tsp_pkg::CON1_CKR] <= 1'b0;
        end
      end
    end
  end

  // sticky event flags, set beats the write-one clear
  always_comb begin
    irq_set = '0;
    irq_set[tsp_pkg::IRQ_START] = start_det && slave && (sp_mode || con3[tsp_pkg::CON3_START_DETECT_IRQ_ENABLE]);
    irq_set[tsp_pkg::IRQ_STOP]  = stop_det && slave && (sp_mode || con3[tsp_pkg::CON3_PCIE]);
    irq_set[tsp_pkg::IRQ_COLL]  = coll && con3[tsp_pkg::CON3_SBCD];
    irq_set[tsp_pkg::IRQ_BYTE]  = (slave || spi_slave) && scl_fall && bitcnt == 4'h8;
    irq_set[tsp_pkg::IRQ_SEQ]   = seq_end;
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_st  <= '0;
      irq_msk <= '0;
      irq_o   <= 1'b0;
    end else begin
      if (wr && req.addr == tsp_pkg::OFF_IRQST) begin
        irq_st <= (irq_st & ~req.wdata[tsp_pkg::IRQ_W-1:0]) | irq_set;
      end else begin
        irq_st <= irq_st | irq_set;
      end
      if (wr && req.addr == tsp_pkg::OFF_IRQMSK) begin
        irq_msk <= req.wdata[tsp_pkg::IRQ_W-1:0];
      end
      irq_o <= |(irq_st & irq_msk);
    end
  end

  // apb answer: one wait state, registered data
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
    end else begin
      pready_o  <= req.sel && req.en && !pready_o;
      pslverr_o <= 1'b0;
      prdata_o  <= '0;
      if (req.sel && req.en && !pready_o) begin
        case (req.addr)
          tsp_pkg::OFF_CON1:   prdata_o <= {24'h000000, con1};
          tsp_pkg::OFF_CON2:   prdata_o <= {24'h000000, con2};
          tsp_pkg::OFF_CON3:   prdata_o <= {24'h000000, con3};
          tsp_pkg::OFF_RELOAD: prdata_o <= {24'h000000, reload};
          tsp_pkg::OFF_BUF:    prdata_o <= {24'h000000, rxbuf};
          tsp_pkg::OFF_IRQST:  prdata_o <= {27'h0000000, irq_st};
          tsp_pkg::OFF_IRQMSK: prdata_o <= {27'h0000000, irq_msk};
          tsp_pkg::OFF_STAT:   prdata_o <= {30'h00000000, busy, bf};
          default:             pslverr_o <= 1'b1;
        endcase
      end
    end
  end

  // self-clearing of sequence bits happens within two divider ticks
  a_seq_clear: assert property (@(posedge clk_i) disable iff (!rstn_i)
    seq_end |=> (con2[4:0] == 5'h00)) else $error("sequence bits not cleared");
  a_busy_nowrite: assert property (@(posedge clk_i) disable iff (!rstn_i)
    busy && wr && req.addr == tsp_pkg::OFF_BUF |=> $stable(txbuf)) else $error("buffer written while busy");
  a_ackt_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !(con3[tsp_pkg::CON3_ADDRESS_HOLD_ENABLE] || con3[tsp_pkg::CON3_DATA_HOLD_ENABLE]) |=> !con3[tsp_pkg::CON3_ACKT]) else $error("ack flag active");
  a_ackt_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
    slave && scl_fall && bitcnt == 4'h8 && con3[1:0] != 2'b00 && !wr |=> con3[tsp_pkg::CON3_ACKT]) else $error("ack flag missed");
  a_ovf_set: assert property (@(posedge clk_i) disable iff (!rstn_i)
    spi_slave && scl_fall && bitcnt == 4'h8 && bf && !wr |=> con1[tsp_pkg::CON1_OVF]) else $error("overflow missed");
  a_buffer_overwrite_enable_write: assert property (@(posedge clk_i) disable iff (!rstn_i)
    spi_slave && scl_fall && bitcnt == 4'h8 && con3[tsp_pkg::CON3_BUFFER_OVERWRITE_ENABLE] |=> rxbuf == $past(shreg)) else $error("buffer not overwritten");
  a_coll_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !con3[tsp_pkg::CON3_SBCD] |-> !irq_set[tsp_pkg::IRQ_COLL]) else $error("collision irq while disabled");
  a_stretch: assert property (@(posedge clk_i) disable iff (!rstn_i)
    slave && !con1[tsp_pkg::CON1_CKR] && !scl_i && !seq_act |=> scl_oe_o) else $error("clock not held low");
endmodule : tsp_ctrl

/* sim/tsp_bus_peer.sv */
// bus peer: behavioural two-wire master that addresses the slave under test
`timescale 1ns/1ps
module tsp_bus_peer #(
  parameter int HALF = 8
) (
  input  wire logic clk_i,
  input  wire logic scl_i,
  output logic      scl_oe_o,
  output logic      sda_oe_o
);
  // both lines released at rest so the pull-ups hold them high
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
  end
  // release the clock, then wait while a slave stretches it; bounded so a stuck line cannot hang us
  task automatic rise();
    int n;
    n = 0;
    @(posedge clk_i) scl_oe_o <= 1'b0;
    while (scl_i !== 1'b1 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (HALF) @(posedge clk_i);
  endtask : rise
  // one full clock pulse, line pulled low again at the end
  task automatic pulse();
    rise();
    scl_oe_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
  endtask : pulse
  // start: data falls while the clock is high
  task automatic start_cond();
    @(posedge clk_i) sda_oe_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
    scl_oe_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
  endtask : start_cond
  // eight data bits msb first, then the acknowledge slot left free for the slave
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sda_oe_o <= ~b[i];
      pulse();
    end
    sda_oe_o <= 1'b0;
    pulse();
  endtask : send_byte
  // stop: data rises while the clock is high
  task automatic stop_cond();
    sda_oe_o <= 1'b1;
    rise();
    sda_oe_o <= 1'b0;
    repeat (HALF) @(posedge clk_i);
  endtask : stop_cond
endmodule : tsp_bus_peer

/* sim/tb_twowire_serial_port_control.sv */
// testbench: apb register, master sequence, interrupt and slave receive checks
`timescale 1ns/1ps
module tb_twowire_serial_port_control;
  logic        clk_i, rstn_i, psel, penable, pwrite;
  logic [7:0]  paddr, rl;
  logic [31:0] pwdata, v, seed;
  logic [34:0] nt;
  logic [34:0] notes[$];
  logic [3:0]  modes[6];
  int          bits[4];
  int          mismatches, comparisons, cyc, n, t0;
  wire  [31:0] prdata;
  wire         pready, pslverr, d_scl_oe, d_sda_oe, p_scl_oe, p_sda_oe, irq;
  // wired-and lines with pull-ups
  wire         scl = ~(d_scl_oe | p_scl_oe);
  wire         sda = ~(d_sda_oe | p_sda_oe);

  tsp_ctrl tsp_ctrl_i (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .scl_i(scl), .sda_i(sda), .scl_oe_o(d_scl_oe), .sda_oe_o(d_sda_oe), .irq_o(irq));
  tsp_bus_peer #(.HALF(8)) tsp_bus_peer_i (.clk_i(clk_i), .scl_i(scl), .scl_oe_o(p_scl_oe), .sda_oe_o(p_sda_oe));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // apb transfer; the note says what the watcher compares (k[1] full, k[0] error flag only)
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] k,
                     input logic [32:0] e);
    @(posedge clk_i);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    notes.push_back({k, e});
    @(posedge clk_i) penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    v = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 2'b00, 33'h0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 2'b10, {1'b0, e});
  endtask : rd

  // the slave must stretch the clock after the byte; release it by setting the clock-release bit
  task automatic held_byte(input logic [7:0] b, input logic [7:0] c3);
    int k;
    k = 0;
    fork
      tsp_bus_peer_i.send_byte(b);
      begin
        while (d_scl_oe !== 1'b1 && k < 3000) begin
          @(posedge clk_i);
          k++;
        end
        check({32'h0, d_scl_oe}, 33'h1);
        rd(tsp_pkg::OFF_CON1, 32'h26);
        rd(tsp_pkg::OFF_CON3, {24'h0, 8'h80 | c3});
        wr(tsp_pkg::OFF_CON1, 32'h36);
      end
    join
    rd(tsp_pkg::OFF_BUF, {24'h0, b});
  endtask : held_byte

  // watcher: oldest note against each answer; also the run ceiling
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      give_verdict();
    end
    if (pready === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt[34]) check({pslverr, prdata}, nt[32:0]);
      else if (nt[33]) check({32'h0, pslverr}, {32'h0, nt[32]});
    end
  end

  initial begin
    {rstn_i, psel, penable, pwrite, paddr, pwdata} = '0;
    {mismatches, comparisons, cyc} = '0;
    seed  = 32'h0000_5629;
    modes = '{tsp_pkg::MODE_S10_SP, tsp_pkg::MODE_S7_SP, tsp_pkg::MODE_FWMST,
              tsp_pkg::MODE_HWMST, tsp_pkg::MODE_S10, tsp_pkg::MODE_S7};
    bits  = '{tsp_pkg::CON2_STRT, tsp_pkg::CON2_RST, tsp_pkg::CON2_STOP, tsp_pkg::CON2_ACK};
    repeat (3) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(tsp_pkg::OFF_CON1, {24'h0, tsp_pkg::RST_CON1});
    rd(tsp_pkg::OFF_CON3, 32'h0);
    apb(1'b0, 8'h20, 32'h0, 2'b01, {1'b1, 32'h0});
    // the six two-wire slave and master mode codes are held as written
    for (int i = 0; i < 6; i++) begin
      wr(tsp_pkg::OFF_CON1, {24'h0, 4'h3, modes[i]});
      rd(tsp_pkg::OFF_CON1, {24'h0, 4'h3, modes[i]});
    end
    // hardware master: each sequence bit runs, rejects new requests, then clears itself
    seed = xs(seed);
    rl   = 8'h0A + {5'h0, seed[2:0]}; // reload kept above two
    wr(tsp_pkg::OFF_RELOAD, {24'h0, rl});
    wr(tsp_pkg::OFF_IRQMSK, 32'h10);
    wr(tsp_pkg::OFF_CON1, 32'h38);
    for (int i = 0; i < 4; i++) begin
      t0 = cyc;
      wr(tsp_pkg::OFF_CON2, 32'h1 << bits[i]);
      rd(tsp_pkg::OFF_STAT, 32'h2);
      // first phase: start, stop and ack pull data low, repeated start releases it; only ack pulls the clock
      check({31'h0, d_scl_oe, d_sda_oe},
            {31'h0, bits[i] == tsp_pkg::CON2_ACK, bits[i] != tsp_pkg::CON2_RST});
      // bit 7 survives the self-clear, so a write slipping through while busy would show in the read below
      wr(tsp_pkg::OFF_CON2, 32'h84);
      wr(tsp_pkg::OFF_BUF, 32'hA5);
      n = 0;
      do begin
        apb(1'b0, tsp_pkg::OFF_CON2, 32'h0, 2'b00, 33'h0);
        n++;
      end while (v[bits[i]] !== 1'b0 && n < 100);
      check({32'h0, (cyc - t0) >= 2 * (rl + 1) && (cyc - t0) <= 2 * (rl + 1) + 20}, 33'h1);
      rd(tsp_pkg::OFF_CON2, 32'h0);
      rd(tsp_pkg::OFF_STAT, 32'h0);
    end
    // sequence-done interrupt: masked, unmasked, cleared
    check({32'h0, irq}, 33'h1);
    wr(tsp_pkg::OFF_IRQMSK, 32'h0);
    repeat (2) @(posedge clk_i);
    check({32'h0, irq}, 33'h0);
    wr(tsp_pkg::OFF_IRQMSK, 32'h10);
    repeat (2) @(posedge clk_i);
    check({32'h0, irq}, 33'h1);
    wr(tsp_pkg::OFF_IRQST, 32'h10);
    repeat (2) @(posedge clk_i);
    check({32'h0, irq}, 33'h0);
    rd(tsp_pkg::OFF_IRQST, 32'h0);
    // slave with address and data holding
    wr(tsp_pkg::OFF_RELOAD, 32'hA4);
    wr(tsp_pkg::OFF_CON3, 32'h3);
    wr(tsp_pkg::OFF_CON1, 32'h36);
    tsp_bus_peer_i.start_cond();
    held_byte(8'hA4, 8'h03);
    held_byte(8'h3C, 8'h03);
    tsp_bus_peer_i.stop_cond();
    // no holding, overwrite on: no acknowledge-time flag, unread byte kept, overflow flagged
    wr(tsp_pkg::OFF_CON3, 32'h10);
    seed = xs(seed);
    tsp_bus_peer_i.start_cond();
    tsp_bus_peer_i.send_byte(8'hA4);
    tsp_bus_peer_i.send_byte(seed[7:0]);
    rd(tsp_pkg::OFF_CON3, 32'h10);
    rd(tsp_pkg::OFF_CON1, 32'h76);
    // a two-wire slave keeps the unread byte even with overwrite on
    rd(tsp_pkg::OFF_BUF, 32'hA4);
    tsp_bus_peer_i.stop_cond();
    // spi slave, overwrite on: the newest byte replaces a full buffer, overflow still flagged
    wr(tsp_pkg::OFF_CON1, 32'h24);
    seed = xs(seed);
    tsp_bus_peer_i.start_cond();
    tsp_bus_peer_i.send_byte(8'h5A);
    tsp_bus_peer_i.send_byte(seed[7:0]);
    tsp_bus_peer_i.stop_cond();
    rd(tsp_pkg::OFF_CON1, 32'h64);
    rd(tsp_pkg::OFF_BUF, {24'h0, seed[7:0]});
    repeat (4) @(posedge clk_i);
    give_verdict();
  end
endmodule : tb_twowire_serial_port_control
